// File: hdl/thermal_overload_output_stage.sv
/*
  Thermal overload output stage: threshold compare, alarms, restart lockout,
  delayed trip, start/blocked handling, condition, load class, setting faults.
  Assumes thermal capacity, current and settings arrive synchronous to
  clk_sys_in, and that process_tick_in marks the start of each program cycle.
*/
//
// Operation
// - Alarm one and its output drive only when its enable is set.
// - Alarm one activates when capacity reaches its threshold, default 40.0 percent.
// - Alarm two and its output are gated by their own enable, default off.
// - Alarm two activates when capacity reaches its threshold, default 40.0 percent.
// - Restart lockout and its output are gated by a separate enable, default off.
// - Lockout activates when capacity reaches its threshold, default 80.0 percent.
// - Trip starts when capacity reaches its threshold, default 100.0 percent; no enable.
// - Trip output waits an added delay in 5 ms steps; zero adds none.
// - Blocking input is sampled once at the start of every program cycle.
// - Pick-up without blocking raises start and proceeds to operate timing.
// - Pick-up with blocking raises blocked and stops further operate processing.
// - Blocking after start clears start and releases as for a dropped pick-up.
// - Condition reports normal, alarms, lockout, trip or blocked; normal drives nothing.
// - Load is light, normal, overloading or high overload from measured current.
// - Invalid service factor raises a fault flag and substitutes 1.0 while present.
// - Invalid ambient settings raise a fault flag and substitute 1.0.
// - Wrong nominal current setup raises a fault flag and substitutes 1.0.
// - Conflicting ambient coefficient settings raise an inconsistency flag while present.
// - Behaviour mode is one of on, blocked, test, test-and-blocked or off.
`include "thermal_overload_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module thermal_overload_output_stage #(
    parameter int unsigned PCT_W        = `TOL_PCT_W,
    parameter int unsigned CUR_W        = `TOL_CUR_W,
    parameter int unsigned DELAY_STEP_CYC = `TOL_DELAY_STEP_CYC
) (
    // Clock and reset
    input  wire logic                               clk_sys_in,
    input  wire logic                               rst_in,
    // Program cycle and measurement
    input  wire logic                               process_tick_in,
    input  wire logic [PCT_W-1:0]                   thermal_capacity_in,
    input  wire logic [CUR_W-1:0]                   measured_current_in,
    input  wire logic [CUR_W-1:0]                   trip_current_limit_in,
    input  wire logic [CUR_W-1:0]                   pickup_current_limit_in,
    // Settings
    input  wire logic                               alarm1_enable_in,
    input  wire logic                               alarm2_enable_in,
    input  wire logic                               inhibit_enable_in,
    input  wire logic [PCT_W-1:0]                   alarm1_level_in,
    input  wire logic [PCT_W-1:0]                   alarm2_level_in,
    input  wire logic [PCT_W-1:0]                   inhibit_level_in,
    input  wire logic [PCT_W-1:0]                   trip_level_in,
    input  wire logic [19:0]                        trip_delay_steps_in,
    input  wire thermal_overload_pkg::behaviour_t   behaviour_in,
    // Blocking matrix input
    input  wire logic                               block_in,
    // Setting validity
    input  wire logic                               service_factor_valid_in,
    input  wire logic [15:0]                        service_factor_in,
    input  wire logic                               ambient_valid_in,
    input  wire logic [15:0]                        ambient_k_in,
    input  wire logic                               nominal_calc_valid_in,
    input  wire logic [15:0]                        nominal_calc_in,
    input  wire logic                               ambient_k_consistent_in,
    // Signals and output controls
    output logic                                    alarm1_out,
    output logic                                    alarm2_out,
    output logic                                    inhibit_out,
    output logic                                    trip_out,
    output logic                                    alarm1_io_out,
    output logic                                    alarm2_io_out,
    output logic                                    inhibit_io_out,
    output logic                                    trip_io_out,
    output logic                                    start_out,
    output logic                                    blocked_out,
    // Status
    output thermal_overload_pkg::condition_t        condition_out,
    output thermal_overload_pkg::behaviour_t        behaviour_out,
    output thermal_overload_pkg::load_class_t       load_class_out,
    output logic                                    service_factor_fault_out,
    output logic                                    ambient_fault_out,
    output logic                                    nominal_fault_out,
    output logic                                    ambient_k_inconsistent_out,
    output logic [15:0]                             service_factor_used_out,
    output logic [15:0]                             ambient_k_used_out,
    output logic [15:0]                             nominal_calc_used_out
);
    import thermal_overload_pkg::*;

    // Narrower fields cannot hold the limits.
    if (PCT_W < 11 || CUR_W < 12 || DELAY_STEP_CYC < 1)
    begin : g_bad_params
        $error("Parameter values too small for the documented ranges.");
    end

    function automatic logic reached(input logic [PCT_W-1:0] cap, input logic [PCT_W-1:0] lvl);
        reached = (cap >= lvl);
    endfunction : reached

    function automatic logic [15:0] used_value(input logic ok, input logic [15:0] val);
        used_value = ok ? val : `TOL_UNITY_Q88;
    endfunction : used_value

    // Blocking is latched only on the program cycle boundary.
    logic           block_r;
    logic           block_nxt;
    logic           mode_block;
    logic           mode_off;
    logic           blk_eff;
    assign block_nxt  = process_tick_in ? block_in : block_r;
    assign mode_block = (behaviour_in == MODE_BLOCKED) || (behaviour_in == MODE_TEST_BLOCKED);
    assign mode_off   = (behaviour_in == MODE_OFF);
    assign blk_eff    = block_r || mode_block;

    // Threshold compares.
    logic           a1_hit;
    logic           a2_hit;
    logic           inh_hit;
    logic           trip_hit;
    assign a1_hit   = reached(thermal_capacity_in, alarm1_level_in);
    assign a2_hit   = reached(thermal_capacity_in, alarm2_level_in);
    assign inh_hit  = reached(thermal_capacity_in, inhibit_level_in);
    assign trip_hit = reached(thermal_capacity_in, trip_level_in);

    // A blocked pick-up yields blocked; otherwise start is raised.
    logic           run;
    logic           start_nxt;
    logic           blocked_nxt;
    assign run         = !mode_off;
    assign start_nxt   = run && trip_hit && !blk_eff;
    assign blocked_nxt = run && trip_hit && blk_eff;

    logic           a1_nxt;
    logic           a2_nxt;
    logic           inh_nxt;
    assign a1_nxt  = run && !blk_eff && alarm1_enable_in && a1_hit;
    assign a2_nxt  = run && !blk_eff && alarm2_enable_in && a2_hit;
    assign inh_nxt = run && !blk_eff && inhibit_enable_in && inh_hit;

    // Trip delay timer; blocking or a drop of pick-up returns it to idle.
    trip_state_t    trip_state_r;
    trip_state_t    trip_state_nxt;
    logic [31:0]    cyc_cnt_r;
    logic [31:0]    cyc_cnt_nxt;
    logic [19:0]    step_cnt_r;
    logic [19:0]    step_cnt_nxt;
    logic           step_done;
    logic           delay_done;
    assign step_done  = (cyc_cnt_r == 32'(DELAY_STEP_CYC - 1));
    assign delay_done = step_done && (step_cnt_r + 20'h00001 >= trip_delay_steps_in);

    always_comb
    begin
        trip_state_nxt = trip_state_r;
        cyc_cnt_nxt    = 32'h00000000;
        step_cnt_nxt   = 20'h00000;
        case (trip_state_r)
            TRIP_IDLE:
            begin
                if (start_nxt)
                    trip_state_nxt = (trip_delay_steps_in == 20'h00000) ? TRIP_ACTIVE : TRIP_DELAY;
            end
            TRIP_DELAY:
            begin
                if (!start_nxt)
                    trip_state_nxt = TRIP_IDLE;
                else if (delay_done)
                    trip_state_nxt = TRIP_ACTIVE;
                else if (step_done)
                    step_cnt_nxt = step_cnt_r + 20'h00001;
                else
                begin
                    cyc_cnt_nxt  = cyc_cnt_r + 32'h00000001;
                    step_cnt_nxt = step_cnt_r;
                end
            end
            TRIP_ACTIVE:
            begin
                if (!start_nxt)
                    trip_state_nxt = TRIP_IDLE;
            end
            default:
                trip_state_nxt = TRIP_IDLE;
        endcase
    end

    // Condition shows the most severe active state.
    condition_t     cond_nxt;
    logic           trip_nxt;
    assign trip_nxt = (trip_state_nxt == TRIP_ACTIVE);
    always_comb
    begin
        if (blocked_nxt)
            cond_nxt = COND_BLOCKED;
        else if (trip_nxt)
            cond_nxt = COND_TRIP;
        else if (inh_nxt)
            cond_nxt = COND_INHIBIT;
        else if (a2_nxt)
            cond_nxt = COND_ALARM2;
        else if (a1_nxt)
            cond_nxt = COND_ALARM1;
        else
            cond_nxt = COND_NORMAL;
    end

    // Output controls stay off in test modes so the relays are not exercised.
    logic           io_allow;
    logic           cond_active;
    logic           a1_io_nxt;
    logic           a2_io_nxt;
    logic           inh_io_nxt;
    logic           trip_io_nxt;

    assign io_allow    = (behaviour_in == MODE_ON);
    assign cond_active = (cond_nxt != COND_NORMAL);
    assign a1_io_nxt   = a1_nxt && io_allow && cond_active;
    assign a2_io_nxt   = a2_nxt && io_allow && cond_active;
    assign inh_io_nxt  = inh_nxt && io_allow && cond_active;
    assign trip_io_nxt = trip_nxt && io_allow && cond_active;

    // Load classification.
    load_class_t    load_nxt;
    always_comb
    begin
        if (measured_current_in < `TOL_LIGHT_LOAD_LIMIT)
            load_nxt = LOAD_LIGHT;
        else if (measured_current_in >= `TOL_HIGH_LOAD_LIMIT)
            load_nxt = LOAD_HIGH;
        else if (measured_current_in > pickup_current_limit_in)
            load_nxt = LOAD_OVER;
        else if (measured_current_in < trip_current_limit_in)
            load_nxt = LOAD_NORMAL;
        else
            load_nxt = LOAD_OVER;
    end

    // Blocking latch and timer state.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            block_r      <= 1'b0;
            trip_state_r <= TRIP_IDLE;
            cyc_cnt_r    <= 32'h00000000;
            step_cnt_r   <= 20'h00000;
        end
        else
        begin
            block_r      <= block_nxt;
            trip_state_r <= trip_state_nxt;
            cyc_cnt_r    <= cyc_cnt_nxt;
            step_cnt_r   <= step_cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            alarm1_out  <= 1'b0;
            alarm2_out  <= 1'b0;
            inhibit_out <= 1'b0;
            trip_out    <= 1'b0;
            start_out   <= 1'b0;
            blocked_out <= 1'b0;
        end
        else
        begin
            alarm1_out  <= a1_nxt;
            alarm2_out  <= a2_nxt;
            inhibit_out <= inh_nxt;
            trip_out    <= trip_nxt;
            start_out   <= start_nxt;
            blocked_out <= blocked_nxt;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            alarm1_io_out  <= 1'b0;
            alarm2_io_out  <= 1'b0;
            inhibit_io_out <= 1'b0;
            trip_io_out    <= 1'b0;
        end
        else
        begin
            alarm1_io_out  <= a1_io_nxt;
            alarm2_io_out  <= a2_io_nxt;
            inhibit_io_out <= inh_io_nxt;
            trip_io_out    <= trip_io_nxt;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            condition_out  <= COND_NORMAL;
            behaviour_out  <= MODE_OFF;
            load_class_out <= LOAD_LIGHT;
        end
        else
        begin
            condition_out  <= cond_nxt;
            behaviour_out  <= behaviour_in;
            load_class_out <= load_nxt;
        end
    end

    // Flags keep no memory; each clears once its setting is valid.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            service_factor_fault_out   <= 1'b0;
            ambient_fault_out          <= 1'b0;
            nominal_fault_out          <= 1'b0;
            ambient_k_inconsistent_out <= 1'b0;
            service_factor_used_out    <= `TOL_UNITY_Q88;
            ambient_k_used_out         <= `TOL_UNITY_Q88;
            nominal_calc_used_out      <= `TOL_UNITY_Q88;
        end
        else
        begin
            service_factor_fault_out   <= !service_factor_valid_in;
            ambient_fault_out          <= !ambient_valid_in;
            nominal_fault_out          <= !nominal_calc_valid_in;
            ambient_k_inconsistent_out <= !ambient_k_consistent_in;
            service_factor_used_out    <= used_value(service_factor_valid_in, service_factor_in);
            ambient_k_used_out         <= used_value(ambient_valid_in, ambient_k_in);
            nominal_calc_used_out      <= used_value(nominal_calc_valid_in, nominal_calc_in);
        end
    end

endmodule : thermal_overload_output_stage

`default_nettype wire

// File: shared/thermal_overload_consts.svh
/*
  Constants for the thermal overload output stage: reset values and timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef THERMAL_OVERLOAD_CONSTS_SVH
`define THERMAL_OVERLOAD_CONSTS_SVH

// Percentages are in tenths of a percent.
`define TOL_PCT_W              11
`define TOL_ALARM1_LEVEL_RST   11'h190
`define TOL_ALARM2_LEVEL_RST   11'h190
`define TOL_INHIBIT_LEVEL_RST  11'h320
`define TOL_TRIP_LEVEL_RST     11'h3E8
`define TOL_PCT_MAX            11'h5DC
// Unity value in a Q8.8 format.
`define TOL_UNITY_Q88          16'h0100
// Current in tenths of a percent of rated current.
`define TOL_CUR_W              16
`define TOL_LIGHT_LOAD_LIMIT   16'h000A
`define TOL_HIGH_LOAD_LIMIT    16'h07D0
// Trip delay step in nanoseconds and the clock period in nanoseconds.
`define TOL_DELAY_STEP_NS      5000000
`define TOL_CLK_PERIOD_NS      5
`define TOL_DELAY_STEP_CYC     ((`TOL_DELAY_STEP_NS + `TOL_CLK_PERIOD_NS - 1) / `TOL_CLK_PERIOD_NS)
`define TOL_DELAY_MAX_STEPS    20'hAFC80
// Blocking lead time that the source must honour, in nanoseconds.
`define TOL_BLOCK_LEAD_NS      5000000

`endif

// File: shared/thermal_overload_pkg.sv
/*
  Types for the thermal overload output stage.
  Assumes the constants header is on the include path.
*/
`default_nettype none

package thermal_overload_pkg;

    typedef enum logic [5:0] {
        COND_NORMAL  = 6'h01,
        COND_ALARM1  = 6'h02,
        COND_ALARM2  = 6'h04,
        COND_INHIBIT = 6'h08,
        COND_TRIP    = 6'h10,
        COND_BLOCKED = 6'h20
    } condition_t;

    typedef enum logic [4:0] {
        MODE_ON           = 5'h01,
        MODE_BLOCKED      = 5'h02,
        MODE_TEST         = 5'h04,
        MODE_TEST_BLOCKED = 5'h08,
        MODE_OFF          = 5'h10
    } behaviour_t;

    typedef enum logic [3:0] {
        LOAD_LIGHT  = 4'h1,
        LOAD_NORMAL = 4'h2,
        LOAD_OVER   = 4'h4,
        LOAD_HIGH   = 4'h8
    } load_class_t;

    typedef enum logic [2:0] {
        TRIP_IDLE    = 3'h1,
        TRIP_DELAY   = 3'h2,
        TRIP_ACTIVE  = 3'h4
    } trip_state_t;

endpackage : thermal_overload_pkg

`default_nettype wire

// File: tb/thermal_overload_output_stage_asserts.sv
/*
  Checker for the thermal overload output stage, watching its top ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_overload_output_stage_asserts
    import thermal_overload_pkg::*;
(
    // Clock, reset and inputs
    input wire logic                             clk_sys_in,
    input wire logic                             rst_in,
    input wire logic [10:0]                      thermal_capacity_in,
    input wire logic                             alarm1_enable_in,
    input wire logic                             alarm2_enable_in,
    input wire logic                             inhibit_enable_in,
    input wire logic [10:0]                      alarm1_level_in,
    input wire logic [10:0]                      trip_level_in,
    input wire logic                             service_factor_valid_in,
    input wire thermal_overload_pkg::behaviour_t behaviour_in,
    // Outputs
    input wire logic                             alarm1_out,
    input wire logic                             alarm2_out,
    input wire logic                             inhibit_out,
    input wire logic                             trip_out,
    input wire logic                             alarm1_io_out,
    input wire logic                             alarm2_io_out,
    input wire logic                             inhibit_io_out,
    input wire logic                             trip_io_out,
    input wire logic                             start_out,
    input wire logic                             blocked_out,
    input wire thermal_overload_pkg::condition_t condition_out,
    input wire thermal_overload_pkg::behaviour_t behaviour_out,
    input wire logic                             service_factor_fault_out,
    input wire logic [15:0]                      service_factor_used_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire a1_hit = thermal_capacity_in >= alarm1_level_in;
    wire trip_hit = thermal_capacity_in >= trip_level_in;
    wire any_io = alarm1_io_out | alarm2_io_out | inhibit_io_out | trip_io_out;

    a_alarm1_gate: assert property (alarm1_out |-> $past(alarm1_enable_in))
        else $error("alarm one active while disabled");
    a_alarm1_level: assert property (alarm1_out |-> $past(a1_hit))
        else $error("alarm one active below its level");
    a_alarm2_gate: assert property (alarm2_out |-> $past(alarm2_enable_in))
        else $error("alarm two active while disabled");
    a_lockout_gate: assert property (inhibit_out |-> $past(inhibit_enable_in))
        else $error("lockout active while disabled");
    a_trip_level: assert property (trip_out |-> $past(trip_hit))
        else $error("trip active below its level");
    a_normal_quiet: assert property (condition_out == COND_NORMAL |-> !any_io)
        else $error("output driven in normal condition");
    a_block_start: assert property (blocked_out |-> !start_out && !trip_out)
        else $error("start or trip while blocked");
    a_sf_flag: assert property (!$past(rst_in) |-> service_factor_fault_out == !$past(service_factor_valid_in))
        else $error("service factor flag wrong");
    a_sf_used: assert property (service_factor_fault_out |-> service_factor_used_out == 16'h0100)
        else $error("service factor not replaced");
    a_mode_copy: assert property (!$past(rst_in) |-> behaviour_out == $past(behaviour_in))
        else $error("behaviour mode not reported");
endmodule : thermal_overload_output_stage_asserts

bind thermal_overload_output_stage thermal_overload_output_stage_asserts u_asserts (
    .clk_sys_in, .rst_in, .thermal_capacity_in, .alarm1_enable_in, .alarm2_enable_in, .inhibit_enable_in,
    .alarm1_level_in, .trip_level_in, .service_factor_valid_in, .behaviour_in, .alarm1_out, .alarm2_out,
    .inhibit_out, .trip_out, .alarm1_io_out, .alarm2_io_out, .inhibit_io_out, .trip_io_out, .start_out,
    .blocked_out, .condition_out, .behaviour_out, .service_factor_fault_out, .service_factor_used_out
);
`default_nettype wire

// File: tb/block_matrix_model.sv
/*
  Blocking matrix model: makes the program cycle tick and the block level.
  Assumes the bench changes block_req_in at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module block_matrix_model #(
    parameter int TICK_N = 4
) (
    // Clock, reset and request
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic block_req_in,
    // To the stage
    output var logic  process_tick_out,
    output var logic  block_out
);
    int cnt_r;
    initial
    begin
        cnt_r = 0;
        process_tick_out = 1'b0;
        block_out = 1'b0;
    end
    // The level lags the request by a cycle, so the bench must ask well ahead of any delay.
    always @(negedge clk_sys_in)
    begin
        cnt_r <= (rst_in || cnt_r == TICK_N - 1) ? 0 : cnt_r + 1;
        process_tick_out <= !rst_in && cnt_r == TICK_N - 1;
        block_out <= block_req_in;
    end
endmodule : block_matrix_model
`default_nettype wire

// File: tb/thermal_overload_output_stage_tb.sv
/*
  Testbench for the thermal overload output stage with a blocking matrix model.
  Assumes a 200 MHz clock and a shortened trip delay step of four cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_overload_output_stage_tb;
    import thermal_overload_pkg::*;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, process_tick_in, block_in, blk_req = 1'b0;
    logic [10:0] thermal_capacity_in = 11'h000, alarm1_level_in = 11'h190, alarm2_level_in = 11'h258;
    logic [10:0] inhibit_level_in = 11'h320, trip_level_in = 11'h3E8;
    logic [15:0] measured_current_in = 16'h0000, lim = 16'h03E8, qv = 16'h0180;
    logic alarm1_enable_in = 1'b1, alarm2_enable_in = 1'b1, inhibit_enable_in = 1'b1;
    logic [19:0] trip_delay_steps_in = 20'h00000;
    logic [3:0] valid = 4'hF;
    behaviour_t behaviour_in = MODE_ON, behaviour_out;
    logic alarm1_out, alarm2_out, inhibit_out, trip_out, alarm1_io_out, alarm2_io_out, inhibit_io_out;
    logic trip_io_out, start_out, blocked_out, sf_f, amb_f, nom_f, k_f;
    condition_t condition_out;
    load_class_t load_class_out;
    logic [15:0] service_factor_used_out, ambient_k_used_out, nominal_calc_used_out;
    int mismatches = 0, n_compared = 0, cycles = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;
    block_matrix_model #(.TICK_N(4)) u_blk (.clk_sys_in, .rst_in, .block_req_in(blk_req),
        .process_tick_out(process_tick_in), .block_out(block_in));
    thermal_overload_output_stage #(.DELAY_STEP_CYC(4)) u_dut (.clk_sys_in, .rst_in, .process_tick_in,
        .thermal_capacity_in, .measured_current_in, .trip_current_limit_in(lim), .pickup_current_limit_in(lim),
        .alarm1_enable_in, .alarm2_enable_in, .inhibit_enable_in, .alarm1_level_in, .alarm2_level_in,
        .inhibit_level_in, .trip_level_in, .trip_delay_steps_in, .behaviour_in, .block_in,
        .service_factor_valid_in(valid[0]), .service_factor_in(qv), .ambient_valid_in(valid[1]),
        .ambient_k_in(qv), .nominal_calc_valid_in(valid[2]), .nominal_calc_in(qv),
        .ambient_k_consistent_in(valid[3]), .alarm1_out, .alarm2_out, .inhibit_out, .trip_out,
        .alarm1_io_out, .alarm2_io_out, .inhibit_io_out, .trip_io_out, .start_out, .blocked_out,
        .condition_out, .behaviour_out, .load_class_out, .service_factor_fault_out(sf_f),
        .ambient_fault_out(amb_f), .nominal_fault_out(nom_f), .ambient_k_inconsistent_out(k_f),
        .service_factor_used_out, .ambient_k_used_out, .nominal_calc_used_out);

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_v

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc

    task automatic t_levels();
        logic [10:0] caps [4] = '{11'h18F, 11'h190, 11'h258, 11'h320};
        logic [5:0] conds [4] = '{6'h01, 6'h02, 6'h04, 6'h08};
        for (int i = 0; i < 4; i++)
        begin
            thermal_capacity_in = caps[i];
            cyc(2);
            chk_v(16'({alarm1_out, alarm1_io_out}), i > 0 ? 16'h0003 : 16'h0000);
            chk_v(16'({alarm2_out, alarm2_io_out}), i > 1 ? 16'h0003 : 16'h0000);
            chk_v(16'({inhibit_out, inhibit_io_out}), i > 2 ? 16'h0003 : 16'h0000);
            chk_v(16'(condition_out), 16'(conds[i]));
        end
        {alarm1_enable_in, alarm2_enable_in, inhibit_enable_in} = 3'h0;
        cyc(2);
        chk_v(16'({alarm1_out, alarm1_io_out, alarm2_out, alarm2_io_out, inhibit_out, inhibit_io_out}), 16'h0000);
        {alarm1_enable_in, alarm2_enable_in, inhibit_enable_in} = 3'h7;
    endtask : t_levels

    task automatic t_trip();
        thermal_capacity_in = 11'h3E7;
        cyc(2);
        chk_v(16'(trip_out), 16'h0000);
        thermal_capacity_in = 11'h3E8;
        cyc(2);
        chk_v(16'({trip_out, trip_io_out, start_out}), 16'h0007);
        chk_v(16'(condition_out), 16'(COND_TRIP));
        thermal_capacity_in = 11'h000;
        trip_delay_steps_in = 20'h00002;
        cyc(3);
        thermal_capacity_in = 11'h3E8;
        cyc(6);
        chk_v(16'(trip_out), 16'h0000);
        cyc(6);
        chk_v(16'(trip_out), 16'h0001);
        thermal_capacity_in = 11'h000;
        trip_delay_steps_in = 20'h00000;
        cyc(3);
    endtask : t_trip

    task automatic t_block();
        blk_req = 1'b1;
        cyc(10);
        thermal_capacity_in = 11'h3E8;
        cyc(3);
        chk_v(16'({blocked_out, start_out, trip_out}), 16'h0004);
        chk_v(16'(condition_out), 16'(COND_BLOCKED));
        blk_req = 1'b0;
        cyc(10);
        chk_v(16'({blocked_out, start_out, trip_out}), 16'h0003);
        blk_req = 1'b1;
        cyc(10);
        chk_v(16'({start_out, trip_out}), 16'h0000);
        blk_req = 1'b0;
        cyc(10);
    endtask : t_block

    task automatic t_modes();
        behaviour_t ms [5] = '{MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF};
        for (int i = 0; i < 5; i++)
        begin
            behaviour_in = ms[i];
            cyc(8);
            chk_v(16'(behaviour_out), 16'(ms[i]));
            chk_v(16'(trip_out), 16'(i == 0 || i == 2));
            chk_v(16'(trip_io_out), 16'(i == 0));
        end
        behaviour_in = MODE_ON;
        thermal_capacity_in = 11'h000;
    endtask : t_modes

    task automatic t_load();
        logic [15:0] curs [4] = '{16'h0005, 16'h000A, 16'h05DC, 16'h07D0};
        for (int i = 0; i < 4; i++)
        begin
            measured_current_in = curs[i];
            cyc(2);
            chk_v(16'(load_class_out), 16'h0001 << i);
        end
    endtask : t_load

    task automatic t_faults();
        for (int i = 0; i < 5; i++)
        begin
            valid = i < 4 ? 4'hF ^ (4'h1 << i) : 4'hF;
            cyc(2);
            chk_v(16'({k_f, nom_f, amb_f, sf_f}), i < 4 ? 16'h0001 << i : 16'h0000);
            chk_v(service_factor_used_out, i == 0 ? 16'h0100 : 16'h0180);
            chk_v(ambient_k_used_out, i == 1 ? 16'h0100 : 16'h0180);
            chk_v(nominal_calc_used_out, i == 2 ? 16'h0100 : 16'h0180);
        end
    endtask : t_faults

    // The ceiling is about twenty times the expected run, so a stuck wait ends the run.
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        cyc(3);
        chk_v(16'({condition_out, behaviour_out}), 16'({COND_NORMAL, MODE_OFF}));
        rst_in = 1'b0;
        cyc(2);
        t_levels();
        t_trip();
        t_block();
        t_modes();
        t_load();
        t_faults();
        give_verdict();
    end
endmodule : thermal_overload_output_stage_tb
`default_nettype wire
